// ### cbs_pkg.sv
// Purpose: shared constants, types and helpers of the bus cycle sequencer
// Assumes: one bus cycle per clk, read/write high means read
// Notes: opcode encodings below cover only the instructions this block sequences
package cbs_pkg;
  // ---------------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_TEST = 8'h00;
  localparam logic [7:0] OP_INTEGER_DIVIDE_INSTR = 8'h02;
  localparam logic [7:0] OP_FRACTIONAL_DIVIDE_INSTR = 8'h03;
  localparam logic [7:0] OP_WAI = 8'h3E;
  localparam logic [7:0] PFX_Y = 8'h18;
  localparam logic [7:0] PFX_D = 8'h1A;
  localparam logic [7:0] PFX_DY = 8'hCD;
  localparam logic [7:0] OP_LDD = 8'hCC;
  localparam logic [7:0] OP_LDS = 8'h8E;
  localparam logic [7:0] OP_LDX = 8'hCE;
  localparam logic [7:0] OP_ADD_DOUBLE_ACC = 8'hC3;
  localparam logic [7:0] OP_CPX = 8'h8C;
  localparam logic [7:0] OP_SUBTRACT_DOUBLE_ACC = 8'h83;
  localparam logic [7:0] OP2_LDY = 8'hEC;
  localparam logic [7:0] OP2_CPY = 8'h8C;
  localparam logic [7:0] OP2_CPD = 8'h83;
  localparam logic [3:0] IMM8_HI_A = 4'h8;
  localparam logic [3:0] IMM8_HI_B = 4'hC;
  localparam logic [15:0] IMM8_LO_MASK = 16'h0F77;
  localparam logic [15:0] ILL_LO_MASK_45 = 16'h4826;
  localparam logic [15:0] ILL_LO_MASK_67 = 16'h0826;
  // ---------------------------------------------------------------
  // addresses and counts
  // ---------------------------------------------------------------
  localparam logic [15:0] DUMMY_ADDR = 16'hFFFF;
  localparam logic [3:0] STACK_LAST = 4'h8;
  localparam logic [5:0] DIV_IDLE = 6'h27;
  localparam logic [5:0] ONE_IDLE = 6'h01;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    CLS_OTHER, CLS_WAI, CLS_DIV, CLS_ILL, CLS_TEST, CLS_IMM8,
    CLS_LD16, CLS_AR16, CLS_LDY, CLS_CP16, CLS_PFX
  } cbs_class_t;
  typedef enum logic [3:0] {
    ST_FETCH, ST_FETCH2, ST_SKIP, ST_OPHI, ST_OPLO, ST_IDLE, ST_PUSH,
    ST_PUSHIDLE, ST_WAIT, ST_VECHI, ST_VECLO, ST_TEST
  } cbs_state_t;
  typedef struct packed {
    logic [15:0] addr;
    logic rw;
    logic [7:0] dout;
    logic doe;
  } cbs_bus_t;
  typedef struct packed {
    logic [7:0] acc_a;
    logic [7:0] acc_b;
    logic [7:0] ccr;
    logic [15:0] index_x;
    logic [15:0] index_y;
    logic [15:0] sp;
  } cbs_regs_t;

  function automatic logic [15:0] stack_addr(input logic [15:0] sp, input logic [3:0] idx);
    stack_addr = sp - {12'h000, idx};
  endfunction : stack_addr
endpackage : cbs_pkg

// ### cbs_opcode_decode.sv
// Purpose: classify a fetched byte into the sequence it starts
// Assumes: paged is high when the byte follows a page prefix
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module cbs_opcode_decode (
  input wire logic paged,
  input wire logic [7:0] pfx,
  input wire logic [7:0] op,
  output cbs_pkg::cbs_class_t cls
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic is_illegal(input logic [7:0] b);
    logic [15:0] mask;
    mask = 16'h0000;
    case (b[7:4])
      4'h4, 4'h5: mask = cbs_pkg::ILL_LO_MASK_45;
      4'h6, 4'h7: mask = cbs_pkg::ILL_LO_MASK_67;
      default: mask = 16'h0000;
    endcase
    is_illegal = mask[b[3:0]];
  endfunction : is_illegal

  function automatic logic is_prefix(input logic [7:0] b);
    is_prefix = (b == cbs_pkg::PFX_Y) || (b == cbs_pkg::PFX_D) || (b == cbs_pkg::PFX_DY);
  endfunction : is_prefix

  logic imm8;
  assign imm8 = ((op[7:4] == cbs_pkg::IMM8_HI_A) || (op[7:4] == cbs_pkg::IMM8_HI_B))
                && cbs_pkg::IMM8_LO_MASK[op[3:0]];

  // ---------------------------------------------------------------
  // classification
  // ---------------------------------------------------------------
  always_comb begin
    cls = cbs_pkg::CLS_OTHER;
    if (!paged) begin
      if (op == cbs_pkg::OP_WAI) cls = cbs_pkg::CLS_WAI;
      else if (op == cbs_pkg::OP_INTEGER_DIVIDE_INSTR || op == cbs_pkg::OP_FRACTIONAL_DIVIDE_INSTR) cls = cbs_pkg::CLS_DIV;
      else if (op == cbs_pkg::OP_TEST) cls = cbs_pkg::CLS_TEST;
      else if (is_prefix(op)) cls = cbs_pkg::CLS_PFX;
      else if (op == cbs_pkg::OP_LDD || op == cbs_pkg::OP_LDS || op == cbs_pkg::OP_LDX)
        cls = cbs_pkg::CLS_LD16;
      else if (op == cbs_pkg::OP_ADD_DOUBLE_ACC || op == cbs_pkg::OP_CPX || op == cbs_pkg::OP_SUBTRACT_DOUBLE_ACC)
        cls = cbs_pkg::CLS_AR16;
      else if (imm8) cls = cbs_pkg::CLS_IMM8;
      else if (is_illegal(op)) cls = cbs_pkg::CLS_ILL;
    end else begin
      if (pfx == cbs_pkg::PFX_Y && op == cbs_pkg::OP2_LDY) cls = cbs_pkg::CLS_LDY;
      else if ((pfx == cbs_pkg::PFX_Y && op == cbs_pkg::OP2_CPY)
               || (pfx == cbs_pkg::PFX_D && op == cbs_pkg::OP2_CPD)) cls = cbs_pkg::CLS_CP16;
      else if (is_illegal(op) || is_prefix(op)) cls = cbs_pkg::CLS_ILL;
    end
  end
endmodule : cbs_opcode_decode
`default_nettype wire

// ### cbs_stack_frame.sv
// Purpose: address and byte of one push of the interrupt frame
// Assumes: idx counts pushes from 0 to 8
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module cbs_stack_frame (
  input wire logic [3:0] idx,
  input wire cbs_pkg::cbs_regs_t regs,
  input wire logic [15:0] ret,
  output logic [15:0] addr,
  output logic [7:0] data
);
  assign addr = cbs_pkg::stack_addr(regs.sp, idx);

  // push order: return, Y, X low byte first, then A, B, CCR
  always_comb begin
    case (idx)
      4'h0: data = ret[7:0];
      4'h1: data = ret[15:8];
      4'h2: data = regs.index_y[7:0];
      4'h3: data = regs.index_y[15:8];
      4'h4: data = regs.index_x[7:0];
      4'h5: data = regs.index_x[15:8];
      4'h6: data = regs.acc_a;
      4'h7: data = regs.acc_b;
      default: data = regs.ccr;
    endcase
  end
endmodule : cbs_stack_frame
`default_nettype wire

// ### cbs_sequencer.sv
// Purpose: cycle by cycle address, read/write and data of the sequenced instructions
// Assumes: memory answers a read within the same cycle; core registers are stable inputs
// Notes: bytes this block does not sequence are handed off with a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module cbs_sequencer #(
  parameter logic [15:0] START_ADDR = 16'h0000,
  parameter logic [15:0] VEC_IRQ = 16'hFFF2,
  parameter logic [15:0] VEC_ILLEGAL = 16'hFFF8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] data_in,
  input wire cbs_pkg::cbs_regs_t regs,
  input wire logic irq_req,
  output cbs_pkg::cbs_bus_t bus,
  output logic [15:0] operand,
  output logic operand_valid,
  output logic [7:0] opcode,
  output logic handoff
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  cbs_pkg::cbs_state_t state, next_state;
  cbs_pkg::cbs_bus_t next_bus;
  cbs_pkg::cbs_class_t cls, dec_cls;
  logic [7:0] pfx;
  logic [15:0] resume;
  logic [15:0] ret_addr;
  logic [5:0] cnt, next_cnt;
  logic [3:0] idx, next_idx;
  logic [7:0] vec_hi;
  logic test_rep;
  logic irq_meta, irq_sync;
  logic [15:0] seq_addr;
  logic [15:0] frame_addr;
  logic [7:0] frame_data;
  logic [15:0] ret_src;
  logic fetching;

  assign fetching = (state == cbs_pkg::ST_FETCH) || (state == cbs_pkg::ST_FETCH2);
  assign seq_addr = bus.addr + 16'h0001;
  assign ret_src = (state == cbs_pkg::ST_SKIP) ? bus.addr : ret_addr;

  cbs_opcode_decode u_decode (
    .paged(state == cbs_pkg::ST_FETCH2),
    .pfx(pfx),
    .op(data_in),
    .cls(dec_cls)
  );

  cbs_stack_frame u_frame (
    .idx(next_idx),
    .regs(regs),
    .ret(ret_src),
    .addr(frame_addr),
    .data(frame_data)
  );

  // ---------------------------------------------------------------
  // interrupt request synchroniser
  // ---------------------------------------------------------------
  // request comes from outside this clock's logic, so two flops first
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_meta <= 1'b0;
      irq_sync <= 1'b0;
    end else begin
      irq_meta <= irq_req;
      irq_sync <= irq_meta;
    end
  end

  // ---------------------------------------------------------------
  // next bus cycle
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_bus.addr = seq_addr;
    next_bus.rw = 1'b1;
    next_bus.dout = 8'h00;
    next_bus.doe = 1'b0;
    next_cnt = cnt;
    next_idx = 4'h0;
    case (state)
      cbs_pkg::ST_FETCH, cbs_pkg::ST_FETCH2: begin
        case (dec_cls)
          cbs_pkg::CLS_PFX: next_state = cbs_pkg::ST_FETCH2;
          cbs_pkg::CLS_WAI, cbs_pkg::CLS_DIV, cbs_pkg::CLS_ILL: begin
            next_state = cbs_pkg::ST_SKIP;
          end
          cbs_pkg::CLS_TEST: next_state = cbs_pkg::ST_TEST;
          cbs_pkg::CLS_IMM8: next_state = cbs_pkg::ST_OPLO;
          cbs_pkg::CLS_LD16, cbs_pkg::CLS_AR16: next_state = cbs_pkg::ST_OPHI;
          cbs_pkg::CLS_LDY, cbs_pkg::CLS_CP16: next_state = cbs_pkg::ST_OPHI;
          default: next_state = cbs_pkg::ST_FETCH;
        endcase
      end
      cbs_pkg::ST_SKIP: begin
        if (cls == cbs_pkg::CLS_WAI) begin
          next_state = cbs_pkg::ST_PUSH;
          next_bus.addr = frame_addr;
          next_bus.rw = 1'b0;
          next_bus.dout = frame_data;
          next_bus.doe = 1'b1;
        end else begin
          next_state = cbs_pkg::ST_IDLE;
          next_bus.addr = cbs_pkg::DUMMY_ADDR;
          // divide idles 39 cycles, a trap only one
          next_cnt = (cls == cbs_pkg::CLS_DIV) ? cbs_pkg::DIV_IDLE : cbs_pkg::ONE_IDLE;
        end
      end
      cbs_pkg::ST_IDLE: begin
        next_bus.addr = cbs_pkg::DUMMY_ADDR;
        next_cnt = cnt - 6'h01;
        if (cnt == cbs_pkg::ONE_IDLE) begin
          if (cls == cbs_pkg::CLS_ILL) begin
            next_state = cbs_pkg::ST_PUSH;
            next_bus.addr = frame_addr;
            next_bus.rw = 1'b0;
            next_bus.dout = frame_data;
            next_bus.doe = 1'b1;
          end else begin
            next_state = cbs_pkg::ST_FETCH;
            next_bus.addr = resume;
          end
        end
      end
      cbs_pkg::ST_OPHI: next_state = cbs_pkg::ST_OPLO;
      cbs_pkg::ST_OPLO: begin
        if (cls == cbs_pkg::CLS_AR16 || cls == cbs_pkg::CLS_CP16) begin
          next_state = cbs_pkg::ST_IDLE;
          next_bus.addr = cbs_pkg::DUMMY_ADDR;
          next_cnt = cbs_pkg::ONE_IDLE;
        end else begin
          next_state = cbs_pkg::ST_FETCH;
        end
      end
      cbs_pkg::ST_PUSH: begin
        if (idx == cbs_pkg::STACK_LAST) begin
          next_bus.addr = cbs_pkg::stack_addr(regs.sp, cbs_pkg::STACK_LAST);
          next_state = (cls == cbs_pkg::CLS_WAI) ? cbs_pkg::ST_WAIT : cbs_pkg::ST_PUSHIDLE;
        end else begin
          next_idx = idx + 4'h1;
          next_bus.addr = frame_addr;
          next_bus.rw = 1'b0;
          next_bus.dout = frame_data;
          next_bus.doe = 1'b1;
        end
      end
      cbs_pkg::ST_WAIT: begin
        next_bus.addr = bus.addr;
        if (irq_sync) begin
          next_state = cbs_pkg::ST_VECHI;
          next_bus.addr = VEC_IRQ;
        end
      end
      cbs_pkg::ST_PUSHIDLE: begin
        next_state = cbs_pkg::ST_VECHI;
        next_bus.addr = VEC_ILLEGAL;
      end
      cbs_pkg::ST_VECHI: next_state = cbs_pkg::ST_VECLO;
      cbs_pkg::ST_VECLO: begin
        next_state = cbs_pkg::ST_FETCH;
        next_bus.addr = {vec_hi, data_in};
      end
      cbs_pkg::ST_TEST: begin
        // only the reset leaves this loop
        next_bus.addr = test_rep ? bus.addr : seq_addr;
      end
      default: begin
        next_state = cbs_pkg::ST_FETCH;
        next_bus.addr = START_ADDR;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // sequencing registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= cbs_pkg::ST_FETCH;
      bus <= '{addr: START_ADDR, rw: 1'b1, dout: 8'h00, doe: 1'b0};
      cnt <= 6'h00;
      idx <= 4'h0;
    end else begin
      state <= next_state;
      bus <= next_bus;
      cnt <= next_cnt;
      idx <= next_idx;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cls <= cbs_pkg::CLS_OTHER;
      pfx <= 8'h00;
      test_rep <= 1'b0;
    end else begin
      test_rep <= fetching && (dec_cls == cbs_pkg::CLS_TEST);
      if (fetching) begin
        cls <= dec_cls;
        if (state == cbs_pkg::ST_FETCH) pfx <= data_in;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      resume <= 16'h0000;
      ret_addr <= 16'h0000;
      vec_hi <= 8'h00;
    end else begin
      // skip address is the byte after the instruction
      if (state == cbs_pkg::ST_SKIP) begin
        resume <= bus.addr;
        ret_addr <= bus.addr;
      end
      if (state == cbs_pkg::ST_OPLO) resume <= seq_addr;
      if (state == cbs_pkg::ST_VECHI) vec_hi <= data_in;
    end
  end

  // ---------------------------------------------------------------
  // results towards the core
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      operand <= 16'h0000;
      operand_valid <= 1'b0;
      opcode <= 8'h00;
      handoff <= 1'b0;
    end else begin
      operand_valid <= (state == cbs_pkg::ST_OPLO);
      handoff <= fetching && (dec_cls == cbs_pkg::CLS_OTHER);
      if (fetching) opcode <= data_in;
      if (fetching) operand <= 16'h0000;
      if (state == cbs_pkg::ST_OPHI) operand[15:8] <= data_in;
      if (state == cbs_pkg::ST_OPLO) operand[7:0] <= data_in;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_wai_skip_read: assert property (
    (state == cbs_pkg::ST_FETCH && dec_cls == cbs_pkg::CLS_WAI)
    |=> (bus.rw && bus.addr == $past(bus.addr) + 16'h0001) ##10 state == cbs_pkg::ST_WAIT)
    else $error("wait sequence skip or stacking length wrong");
  a_push_write: assert property (
    state == cbs_pkg::ST_PUSH
    |-> (!bus.rw && bus.doe && bus.addr == cbs_pkg::stack_addr(regs.sp, idx)))
    else $error("push cycle not a write below the stack pointer");
  a_wait_hold: assert property (
    state == cbs_pkg::ST_WAIT
    |-> (bus.rw && !bus.doe
         && bus.addr == cbs_pkg::stack_addr(regs.sp, cbs_pkg::STACK_LAST)))
    else $error("wait cycle not a read at the last stack slot");
  a_vector_pair: assert property (
    state == cbs_pkg::ST_VECHI
    |=> (state == cbs_pkg::ST_VECLO && bus.addr == $past(bus.addr) + 16'h0001))
    else $error("vector low byte not read at vector plus one");
  a_div_length: assert property (
    (state == cbs_pkg::ST_SKIP && cls == cbs_pkg::CLS_DIV)
    |=> (bus.addr == cbs_pkg::DUMMY_ADDR && bus.rw) ##39 state == cbs_pkg::ST_FETCH)
    else $error("divide does not take 41 cycles");
  a_trap_length: assert property (
    (state == cbs_pkg::ST_FETCH && dec_cls == cbs_pkg::CLS_ILL)
    |-> ##2 bus.addr == cbs_pkg::DUMMY_ADDR ##13 state == cbs_pkg::ST_FETCH)
    else $error("page 1 trap does not take 15 cycles");
  a_page_trap: assert property (
    (state == cbs_pkg::ST_FETCH2 && dec_cls == cbs_pkg::CLS_ILL)
    |-> ##2 bus.addr == cbs_pkg::DUMMY_ADDR ##13 state == cbs_pkg::ST_FETCH)
    else $error("paged trap does not take 16 cycles");
  a_test_walk: assert property (
    (state == cbs_pkg::ST_FETCH && dec_cls == cbs_pkg::CLS_TEST)
    |=> (bus.addr == $past(bus.addr) + 16'h0001) ##1 (bus.addr == $past(bus.addr))
        ##1 (bus.addr == $past(bus.addr) + 16'h0001) ##1 (bus.addr == $past(bus.addr) + 16'h0001))
    else $error("test opcode address walk wrong");
  a_imm8_len: assert property (
    (state == cbs_pkg::ST_FETCH && dec_cls == cbs_pkg::CLS_IMM8)
    |=> bus.addr == $past(bus.addr) + 16'h0001 ##1 state == cbs_pkg::ST_FETCH)
    else $error("8-bit immediate not two reads");
  a_ld16_len: assert property (
    (state == cbs_pkg::ST_FETCH && dec_cls == cbs_pkg::CLS_LD16)
    |-> ##3 (state == cbs_pkg::ST_FETCH && bus.addr == $past(bus.addr, 3) + 16'h0003))
    else $error("16-bit immediate load not three reads");
  a_ar16_idle: assert property (
    (state == cbs_pkg::ST_FETCH && dec_cls == cbs_pkg::CLS_AR16)
    |-> ##3 bus.addr == cbs_pkg::DUMMY_ADDR ##1 state == cbs_pkg::ST_FETCH)
    else $error("16-bit immediate arithmetic not four cycles");
  a_ldy_len: assert property (
    (state == cbs_pkg::ST_FETCH2 && dec_cls == cbs_pkg::CLS_LDY)
    |-> ##3 (state == cbs_pkg::ST_FETCH && bus.addr == $past(bus.addr, 3) + 16'h0003))
    else $error("immediate load of Y not four reads");
  a_cp16_idle: assert property (
    (state == cbs_pkg::ST_FETCH2 && dec_cls == cbs_pkg::CLS_CP16)
    |-> ##3 bus.addr == cbs_pkg::DUMMY_ADDR ##1 state == cbs_pkg::ST_FETCH)
    else $error("immediate compare of D or Y not five cycles");
  a_irq_exit: assert property (
    (state == cbs_pkg::ST_WAIT && irq_sync) |=> (state == cbs_pkg::ST_VECHI && bus.addr == VEC_IRQ))
    else $error("wait did not leave on interrupt");

  c_wai_wake: cover property (state == cbs_pkg::ST_WAIT ##1 state == cbs_pkg::ST_VECHI);
  c_trap_taken: cover property (state == cbs_pkg::ST_PUSHIDLE ##1 state == cbs_pkg::ST_VECHI);
  c_div_done: cover property (state == cbs_pkg::ST_IDLE && cls == cbs_pkg::CLS_DIV
                              ##1 state == cbs_pkg::ST_FETCH);
  c_cp16_done: cover property (state == cbs_pkg::ST_IDLE && cls == cbs_pkg::CLS_CP16);
endmodule : cbs_sequencer
`default_nettype wire

// ### cbs_mem_model.sv
// Purpose: memory on the far side of the sequencer bus
// Assumes: reads answer in the same cycle, writes land at the edge ending the cycle
// Notes: no wait states exist on this bus
`timescale 1ns/1ps
`default_nettype none
module cbs_mem (
  input wire logic clk,
  input wire cbs_pkg::cbs_bus_t bus,
  output logic [7:0] data_in
);
  logic [7:0] mem [0:65535];
  logic [7:0] last;
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'(i) ^ 8'hA5;
    last = 8'h00;
  end
  // plain always: the bench also loads this array and the initial clears last
  always @(posedge clk) begin
    if (!bus.rw && bus.doe) mem[bus.addr] <= bus.dout;
    if (bus.rw) last <= mem[bus.addr];
  end
  // released line on writes: inverse of last byte, never a stale copy
  assign data_in = bus.rw ? mem[bus.addr] : ~last;
endmodule : cbs_mem
`default_nettype wire

// ### cbs_testbench.sv
// Purpose: cycle by cycle check of the sequencer against a queue model
// Assumes: program image loaded into the memory model before reset release
// Notes: wait length is bounded around the random irq delay
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [15:0] VIL = 16'hFFF8;
  localparam logic [15:0] VIRQ = 16'hFFF2;
  localparam logic [15:0] DMY = 16'hFFFF;
  typedef struct {logic [15:0] a; logic rw; logic [7:0] d; bit wt;} cbs_exp_t;
  logic clk, rst_b, irq_req, operand_valid, handoff;
  logic [7:0] data_in, opcode;
  logic [15:0] operand;
  cbs_pkg::cbs_regs_t regs;
  cbs_pkg::cbs_bus_t bus;
  cbs_exp_t q[$];
  logic [23:0] opq[$];
  logic [7:0] prog [0:18];
  int errors, checked, nw, nho, dly, cyc;
  cbs_sequencer #(.START_ADDR(16'h0000), .VEC_IRQ(VIRQ), .VEC_ILLEGAL(VIL)) dut_u (
    .clk(clk), .rst_b(rst_b), .data_in(data_in), .regs(regs), .irq_req(irq_req),
    .bus(bus), .operand(operand), .operand_valid(operand_valid), .opcode(opcode),
    .handoff(handoff));
  cbs_mem mem_u (.clk(clk), .bus(bus), .data_in(data_in));
  always #25 clk = ~clk;
  // ---------------------------------------------------------------
  // model and compares
  // ---------------------------------------------------------------
  task automatic px(input logic [15:0] a, input logic rw, input logic [7:0] d, input bit wt);
    q.push_back('{a, rw, d, wt});
  endtask : px
  task automatic rd(input logic [15:0] a, input int n, input bit inc);
    for (int i = 0; i < n; i++) px(a + (inc ? 16'(i) : 16'h0000), 1'b1, 8'h00, 1'b0);
  endtask : rd
  task automatic frame(input logic [15:0] ret);
    logic [7:0] b [9];
    b = '{ret[7:0], ret[15:8], regs.index_y[7:0], regs.index_y[15:8], regs.index_x[7:0],
      regs.index_x[15:8], regs.acc_a, regs.acc_b, regs.ccr};
    for (int i = 0; i < 9; i++) px(regs.sp - 16'(i), 1'b0, b[i], 1'b0);
    rd(regs.sp - 16'h0008, 1, 1'b0);
  endtask : frame
  task automatic fail(input string s);
    errors++;
    $display("[FAIL] %0t %s", $time, s);
  endtask : fail
  task automatic chk_bus(input cbs_exp_t e);
    checked++;
    if (bus.addr !== e.a || bus.rw !== e.rw || (!e.rw && (bus.dout !== e.d || bus.doe !== 1'b1)))
      fail($sformatf("bus %h/%b/%h want %h/%b/%h", bus.addr, bus.rw, bus.dout, e.a, e.rw, e.d));
  endtask : chk_bus
  task automatic chk_op(input logic [23:0] e);
    checked++;
    if (operand !== e[15:0] || opcode !== e[23:16])
      fail($sformatf("opcode/operand %h/%h want %h", opcode, operand, e));
  endtask : chk_op
  task automatic chk_num(input int got, input int lo, input int hi);
    checked++;
    if (got < lo || got > hi) fail($sformatf("count %0d outside %0d..%0d", got, lo, hi));
  endtask : chk_num
  task automatic wrap_up;
    if (errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  always @(negedge clk) begin
    if (rst_b && handoff === 1'b1) nho++;
    if (rst_b && operand_valid === 1'b1) chk_op(opq.size() > 0 ? opq.pop_front() : 24'hXXXXXX);
    if (rst_b && q.size() > 0) begin
      if (q[0].wt && bus.addr === q[0].a && bus.rw === 1'b1) nw++;
      else begin
        if (q[0].wt) void'(q.pop_front());
        chk_bus(q.pop_front());
      end
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      fail("timeout");
      wrap_up();
    end
  end
  // irq only once the wait reads have begun
  initial begin
    wait (q.size() > 0 && q[0].wt);
    repeat (dly) @(posedge clk);
    irq_req <= 1'b1;
    wait (bus.addr === VIRQ);
    @(posedge clk);
    irq_req <= 1'b0;
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    irq_req = 1'b0;
    void'($urandom(32'h67CD4530));
    dly = $urandom_range(6);
    regs = {24'($urandom), 32'($urandom), 4'h8, 12'($urandom)};
    // let the memory model fill its image with its default pattern first, then load the program
    #1;
    for (int i = 0; i < 19; i++) prog[i] = 8'($urandom);
    prog[0] = 8'h01;
    prog[1] = $urandom_range(1) ? 8'hC6 : 8'h86;
    {prog[3], prog[6], prog[9], prog[10], prog[13], prog[14]} = 48'hCCC318EC1A83;
    {prog[17], prog[18]} = 16'h0241;
    for (int i = 0; i < 19; i++) mem_u.mem[i] = prog[i];
    {mem_u.mem[16'h0040], mem_u.mem[16'h0060], mem_u.mem[16'h0061]} = 24'h3E1841;
    {mem_u.mem[VIL], mem_u.mem[VIL + 1], mem_u.mem[VIRQ], mem_u.mem[VIRQ + 1]} = 32'h00400060;
    rd(16'h0000, 1, 1'b0);
    rd(16'h0001, 2, 1'b1); opq.push_back({prog[1], 8'h00, prog[2]});
    rd(16'h0003, 3, 1'b1); opq.push_back({prog[3], prog[4], prog[5]});
    rd(16'h0006, 3, 1'b1); rd(DMY, 1, 1'b0); opq.push_back({prog[6], prog[7], prog[8]});
    rd(16'h0009, 4, 1'b1); opq.push_back({prog[10], prog[11], prog[12]});
    rd(16'h000D, 4, 1'b1); rd(DMY, 1, 1'b0); opq.push_back({prog[14], prog[15], prog[16]});
    rd(16'h0011, 2, 1'b1); rd(DMY, 39, 1'b0);
    rd(16'h0012, 2, 1'b1); rd(DMY, 1, 1'b0); frame(16'h0013); rd(VIL, 2, 1'b1);
    rd(16'h0040, 2, 1'b1); frame(16'h0041);
    px(regs.sp - 16'h0008, 1'b1, 8'h00, 1'b1); rd(VIRQ, 2, 1'b1);
    rd(16'h0060, 3, 1'b1); rd(DMY, 1, 1'b0); frame(16'h0062); rd(VIL, 2, 1'b1);
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    wait (q.size() == 0);
    @(posedge clk);
    rst_b <= 1'b0;
    mem_u.mem[0] = 8'h00;
    rd(16'h0000, 1, 1'b0); rd(16'h0001, 2, 1'b0); rd(16'h0002, 20, 1'b1);
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    wait (q.size() == 0);
    chk_num(nw, dly, dly + 4);
    chk_num(opq.size(), 0, 0);
    chk_num(nho, 1, 1);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
